/* File: pkg/gis_cfg.svh */
`ifndef GIS_CFG_SVH
`define GIS_CFG_SVH
// What this block does
// - Service request flag only while controller in charge
// - Bit 6 sets on rising CIC, SRQ, not own
// - Event flags clear cycle after register read
// - Bit 5 shows lockout, never an interrupt
// - Bit 4 shows remote or remote-with-lockout
// - Enter remote on REN with listener addressing
// - Bit 3 sets when active and generate true
// - Bit 3 clears on read or state left
// - Bit 2 sets on any lockout change
// - Bit 1 sets on any remote change
// - Bit 0 sets on address change unless only-modes
// - Watch address bits 1, 2, 7, 0
// - Listen-only bit 6, talk-only bit 7 mask detection
// - Enable bit at same position per flag
`define GIS_BIT_SRQ_IN   6
`define GIS_BIT_LOCK     5
`define GIS_BIT_FAR      4
`define GIS_BIT_CMD_RDY  3
`define GIS_BIT_LOCKC    2
`define GIS_BIT_FARC     1
`define GIS_BIT_ADDR_CHG 0
`define GIS_BIT_DMA_OUT  5
`define GIS_BIT_DMA_IN   4
`define GIS_ADS_PRI_SEC  0
`define GIS_ADS_SPEAKER  1
`define GIS_ADS_LISTENER 2
`define GIS_ADS_CIC    7
`define GIS_ADM_LON    6
`define GIS_ADM_TON    7
`define GIS_EVENT_MASK 8'h4F
`define GIS_ENABLE_RST 8'h00
`define GIS_RD_RST     8'h00
`endif

/* File: pkg/gis_pkg.sv */
package gis_pkg;
   typedef enum logic [1:0] {
      GIS_LOCS = 2'b00,
      GIS_REMS = 2'b01,
      GIS_RWLS = 2'b10,
      GIS_LWLS = 2'b11
   } gis_rl_state_t;
endpackage : gis_pkg

/* File: hw/gis_status_bank.sv */
`timescale 1ns/1ps
`include "gis_cfg.svh"
module gis_status_bank (
   input  wire logic       sys_clk_i,
   input  wire logic       reset_n_i,
   input  wire logic       rd_strobe_i,
   input  wire logic       wr_strobe_i,
   input  wire logic [7:0] wr_data_i,
   input  wire logic [7:0] addr_state_register_i,
   input  wire logic [7:0] addr_mode_register_i,
   input  wire logic       srq_i,
   input  wire logic       rqs_i,
   input  wire logic       dav_i,
   input  wire logic       cacs_i,
   input  wire logic       sgns_i,
   input  wire logic       ren_i,
   input  wire logic       llo_i,
   input  wire logic       gtl_i,
   output logic      [7:0] rd_data_o,
   output logic            irq_o,
   output logic            lockout_flag_o,
   output logic            far_control_flag_o,
   output logic      [1:0] rl_state_o
);
   gis_pkg::gis_rl_state_t rl_q;
   gis_pkg::gis_rl_state_t rl_d;
   logic [7:0] enable_q;
   logic [7:0] ev_q;
   logic [7:0] ev_d;
   logic [7:0] rd_data_q;
   logic       irq_q;
   logic       lock_q;
   logic       far_q;
   logic       srq_cond_q;
   logic       co_cond_q;
   logic [3:0] ads_prev_q;
   logic       cic;
   logic       listener_addr;
   logic       srq_cond;
   logic       co_cond;
   logic       lock_now;
   logic       far_now;
   logic [3:0] ads_now;
   logic       only_mode;

   assign cic       = addr_state_register_i[`GIS_ADS_CIC];
   assign listener_addr = addr_state_register_i[`GIS_ADS_LISTENER];
   // Service request from elsewhere only counts while in charge
   assign srq_cond  = cic & srq_i & ~(rqs_i & dav_i);
   assign co_cond   = cacs_i & sgns_i;
   assign ads_now   = {addr_state_register_i[`GIS_ADS_CIC],
                       addr_state_register_i[`GIS_ADS_LISTENER],
                       addr_state_register_i[`GIS_ADS_SPEAKER],
                       addr_state_register_i[`GIS_ADS_PRI_SEC]};
   assign only_mode = addr_mode_register_i[`GIS_ADM_LON]
                    | addr_mode_register_i[`GIS_ADM_TON];

   // Remote/local function, simplified to the four stable states
   always_comb begin
      rl_d = rl_q;
      if (!ren_i) begin
         rl_d = gis_pkg::GIS_LOCS;
      end else begin
         unique case (rl_q)
            gis_pkg::GIS_LOCS: begin
               if (llo_i) begin
                  rl_d = gis_pkg::GIS_LWLS;
               end else if (listener_addr) begin
                  rl_d = gis_pkg::GIS_REMS;
               end
            end
            gis_pkg::GIS_REMS: begin
               if (llo_i) begin
                  rl_d = gis_pkg::GIS_RWLS;
               end else if (gtl_i && listener_addr) begin
                  rl_d = gis_pkg::GIS_LOCS;
               end
            end
            gis_pkg::GIS_RWLS: begin
               if (gtl_i && listener_addr) begin
                  rl_d = gis_pkg::GIS_LWLS;
               end
            end
            gis_pkg::GIS_LWLS: begin
               if (listener_addr && !gtl_i) begin
                  rl_d = gis_pkg::GIS_RWLS;
               end
            end
         endcase
      end
   end

   assign lock_now = (rl_d == gis_pkg::GIS_RWLS) | (rl_d == gis_pkg::GIS_LWLS);
   assign far_now  = (rl_d == gis_pkg::GIS_REMS) | (rl_d == gis_pkg::GIS_RWLS);

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rl_q   <= gis_pkg::GIS_LOCS;
         lock_q <= 1'b0;
         far_q  <= 1'b0;
      end else begin
         rl_q   <= rl_d;
         lock_q <= lock_now;
         far_q  <= far_now;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         srq_cond_q <= 1'b0;
         co_cond_q  <= 1'b0;
         ads_prev_q <= 4'h0;
      end else begin
         srq_cond_q <= srq_cond;
         co_cond_q  <= co_cond;
         ads_prev_q <= ads_now;
      end
   end

   // A new event in the read cycle survives the clear
   always_comb begin
      ev_d = rd_strobe_i ? 8'h00 : ev_q;
      if (srq_cond && !srq_cond_q) begin
         ev_d[`GIS_BIT_SRQ_IN] = 1'b1;
      end
      if (!co_cond) begin
         ev_d[`GIS_BIT_CMD_RDY] = 1'b0;
      end else if (!co_cond_q) begin
         ev_d[`GIS_BIT_CMD_RDY] = 1'b1;
      end
      if (lock_now != lock_q) begin
         ev_d[`GIS_BIT_LOCKC] = 1'b1;
      end
      if (far_now != far_q) begin
         ev_d[`GIS_BIT_FARC] = 1'b1;
      end
      if ((ads_now != ads_prev_q) && !only_mode) begin
         ev_d[`GIS_BIT_ADDR_CHG] = 1'b1;
      end
      ev_d = ev_d & `GIS_EVENT_MASK;
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ev_q <= 8'h00;
      end else begin
         ev_q <= ev_d;
      end
   end

   // DMA bits are stored as written but drive nothing
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         enable_q <= `GIS_ENABLE_RST;
      end else if (wr_strobe_i) begin
         enable_q <= wr_data_i;
      end
   end

   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rd_data_q <= `GIS_RD_RST;
      end else if (rd_strobe_i) begin
         rd_data_q <= (ev_q & `GIS_EVENT_MASK)
                    | ({7'h00, lock_q} << `GIS_BIT_LOCK)
                    | ({7'h00, far_q} << `GIS_BIT_FAR);
      end
   end

   // Only event bits gate the request; live bits 5 and 4 never do
   always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         irq_q <= 1'b0;
      end else begin
         irq_q <= |(ev_d & enable_q & `GIS_EVENT_MASK);
      end
   end

   assign rd_data_o          = rd_data_q;
   assign irq_o              = irq_q;
   assign lockout_flag_o     = lock_q;
   assign far_control_flag_o = far_q;
   assign rl_state_o         = rl_q;
endmodule : gis_status_bank

/* File: verification/gis_status_monitor.sv */
`timescale 1ns/1ps
module gis_status_monitor (
   input wire logic       sys_clk_i, reset_n_i, rd_strobe_i, wr_strobe_i, cacs_i, sgns_i,
   input wire logic [7:0] wr_data_i, rd_data_o,
   input wire logic       irq_o, lockout_flag_o, far_control_flag_o,
   input wire logic [1:0] rl_state_o
);
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (!reset_n_i);
   a_live_flags: assert property (
      lockout_flag_o == rl_state_o[1] && far_control_flag_o == ^rl_state_o)
      else $error("live flags wrong");
   a_read_live: assert property (
      rd_strobe_i |=> !rd_data_o[7] && rd_data_o[5:4] == $past({lockout_flag_o, far_control_flag_o}))
      else $error("read live bits wrong");
   a_lock_change: assert property ($changed(lockout_flag_o) && rd_strobe_i |=> rd_data_o[2])
      else $error("lockout change lost");
   a_far_change: assert property ($changed(far_control_flag_o) && rd_strobe_i |=> rd_data_o[1])
      else $error("far change lost");
   a_read_clear: assert property (
      rd_strobe_i ##1 (rd_strobe_i && $stable(rl_state_o)) |=> rd_data_o[2:1] == 2'b00)
      else $error("flags not cleared by read");
   a_cmd_set: assert property ($rose(cacs_i && sgns_i) ##1 rd_strobe_i |=> rd_data_o[3])
      else $error("command ready not set");
   a_cmd_drop: assert property (!(cacs_i && sgns_i) ##1 rd_strobe_i |=> !rd_data_o[3])
      else $error("command ready not dropped");
   a_irq_masked: assert property (
      wr_strobe_i && (wr_data_i & 8'h4F) == 8'h00 ##1 !wr_strobe_i |=> !irq_o)
      else $error("interrupt with no enable");
   c_back_read: cover property (rd_strobe_i ##1 rd_strobe_i);
   c_irq_up: cover property ($rose(irq_o));
   c_lockout: cover property (rl_state_o == 2'b10);
   c_local_lock: cover property (rl_state_o == 2'b11);
endmodule : gis_status_monitor
bind gis_status_bank gis_status_monitor u_mon (.*);

/* File: verification/gis_bus_model.sv */
`timescale 1ns/1ps
module gis_bus_model (
   input  wire logic       sys_clk_i,
   input  wire logic [3:0] cmd_i,
   output logic            ren_o, llo_o, gtl_o, srq_o
);
   // Lines follow a request one clock late, as a slow instrument would
   // Bench holds commands at zero through reset, so lines settle before release
   always @(posedge sys_clk_i) {srq_o, gtl_o, llo_o, ren_o} <= cmd_i;
endmodule : gis_bus_model

/* File: verification/testbench.sv */
`timescale 1ns/1ps
module testbench;
   logic       sys_clk_i = 0, reset_n_i = 0, rd_strobe_i = 0, wr_strobe_i = 0, irq_o;
   logic       rqs = 0, dav = 0, cacs = 0, sgns = 0, ren, llo, gtl, srq, lk, fc;
   logic [7:0] wr_data_i = 0, ads = 0, adm = 0, rd_data_o;
   logic [3:0] bus = 0;
   logic [1:0] rl;
   int         bad_count = 0, total_checks = 0;
   initial forever #50 sys_clk_i = ~sys_clk_i;
   gis_bus_model u_bus (.sys_clk_i, .cmd_i(bus), .ren_o(ren), .llo_o(llo), .gtl_o(gtl),
      .srq_o(srq));
   gis_status_bank u_dut (.sys_clk_i, .reset_n_i, .rd_strobe_i, .wr_strobe_i, .wr_data_i,
      .addr_state_register_i(ads), .addr_mode_register_i(adm), .srq_i(srq), .rqs_i(rqs),
      .dav_i(dav), .cacs_i(cacs), .sgns_i(sgns), .ren_i(ren), .llo_i(llo), .gtl_i(gtl),
      .rd_data_o, .irq_o, .lockout_flag_o(lk), .far_control_flag_o(fc), .rl_state_o(rl));
   task results;
      if (bad_count == 0 && total_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : results
   task chk(input logic [7:0] s, e);
      total_checks++;
      if (s !== e) begin
         bad_count++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask : chk
   task tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask : tick
   task rd(input logic [7:0] e);
      @(posedge sys_clk_i) rd_strobe_i <= 1;
      @(posedge sys_clk_i) rd_strobe_i <= 0;
      #1 chk(rd_data_o, e);
   endtask : rd
   task wr(input logic [7:0] d);
      @(posedge sys_clk_i) wr_data_i <= d;
      wr_strobe_i <= 1;
      @(posedge sys_clk_i) wr_strobe_i <= 0;
   endtask : wr
   task wait_rl(input logic [1:0] e);
      int n;
      for (n = 0; n < 8 && rl !== e; n++) @(posedge sys_clk_i);
      chk({6'h0, rl}, {6'h0, e});
      if (rl !== e) results();
   endtask : wait_rl
   task t_reset;
      tick(1);
      chk({rd_data_o[7:1], irq_o}, 8'h00);
      rd(8'h00);
   endtask : t_reset
   task t_remote;
      @(posedge sys_clk_i) bus <= 4'h1;
      ads <= 8'h04;
      wait_rl(2'b01);
      rd(8'h13);
      @(posedge sys_clk_i) bus <= 4'h3;
      wait_rl(2'b10);
      rd(8'h34);
      rd(8'h30);
      @(posedge sys_clk_i) bus <= 4'h0;
      wait_rl(2'b00);
      rd(8'h06);
   endtask : t_remote
   task t_addr_state_change_flag;
      @(posedge sys_clk_i) adm <= 8'h40;
      ads <= 8'h06;
      rd(8'h00);
      @(posedge sys_clk_i) adm <= 8'h80;
      ads <= 8'h04;
      rd(8'h00);
      @(posedge sys_clk_i) adm <= 8'h00;
      ads <= 8'h05;
      rd(8'h01);
   endtask : t_addr_state_change_flag
   task t_srq;
      @(posedge sys_clk_i) ads <= 8'h85;
      bus <= 4'h8;
      rqs <= 1;
      dav <= 1;
      rd(8'h01);
      @(posedge sys_clk_i) rqs <= 0;
      rd(8'h40);
      @(posedge sys_clk_i) ads <= 8'h05;
      bus <= 4'h0;
      tick(2);
      @(posedge sys_clk_i) bus <= 4'h8;
      tick(2);
      rd(8'h01);
   endtask : t_srq
   task t_co;
      @(posedge sys_clk_i) cacs <= 1;
      sgns <= 1;
      rd(8'h08);
      @(posedge sys_clk_i) rd_strobe_i <= 1;
      @(posedge sys_clk_i);
      @(posedge sys_clk_i) rd_strobe_i <= 0;
      #1 chk(rd_data_o, 8'h00);
      @(posedge sys_clk_i) sgns <= 0;
      @(posedge sys_clk_i) sgns <= 1;
      @(posedge sys_clk_i) sgns <= 0;
      rd(8'h00);
   endtask : t_co
   task t_irq;
      wr(8'h08);
      @(posedge sys_clk_i) sgns <= 1;
      tick(2);
      chk({7'h0, irq_o}, 8'h01);
      wr(8'h00);
      tick(1);
      chk({7'h0, irq_o}, 8'h00);
      wr(8'h08);
      tick(1);
      chk({7'h0, irq_o}, 8'h01);
      rd(8'h08);
      tick(1);
      chk({7'h0, irq_o}, 8'h00);
   endtask : t_irq
   // Lockout paths through local-with-lockout, with go-to-local on and off
   task t_gtl;
      @(posedge sys_clk_i) bus <= 4'h7;
      wait_rl(2'b11);
      rd(8'h24);
      @(posedge sys_clk_i) bus <= 4'h3;
      wait_rl(2'b10);
      rd(8'h32);
      @(posedge sys_clk_i) bus <= 4'h5;
      wait_rl(2'b11);
      rd(8'h22);
      chk({7'h0, irq_o}, 8'h00);
   endtask : t_gtl
   initial begin
      repeat (12) @(posedge sys_clk_i);
      reset_n_i <= 1;
      t_reset;
      t_remote;
      t_addr_state_change_flag;
      t_srq;
      t_co;
      t_irq;
      t_gtl;
      results;
   end
endmodule : testbench
